// >>> hdl/uab_autobaud_wake.sv
/*
 * uab_autobaud_wake: receive-side support of a serial port unit.
 * holds autobaud calibration of the baud divisor, overflow detect and
 * wake-on-break detection of the serial receive line.
 * assumes: serialReceiveLine synchronous to clk; control bits and
 * strobes come from a register front end outside; sleep modelled by
 * an input flag (clk keeps running in this model).
 */
module uab_autobaud_wake (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // serial line
   input wire logic serialReceiveLine,
   // control bits written by software
   input wire logic autobaudEnableSet,    // pulse: set enable
   input wire logic autobaudEnableClear,  // pulse: clear enable
   input wire logic wakeOnBreakEnableSet, // pulse: set enable
   input wire logic overflowFlagClear,    // pulse: clear overflow
   input wire logic wideDivisorSelect,
   input wire logic highSpeedSelect,
   input wire logic synchronousMode,
   input wire logic sleepMode,
   // divisor write by software
   input wire logic divisorWrite,         // pulse
   input wire logic [15:0] divisorWriteData,
   // receive data register read strobe
   input wire logic receiveDataRead,      // pulse
   // receiver side: character received by the normal datapath
   input wire logic receiverCharDone,     // pulse
   input wire logic receiverBusy,         // level
   // status outputs
   output logic autobaudEnable,
   output logic autobaudOverflowFlag,
   output logic wakeOnBreakEnable,
   output logic receiveInterruptFlag,
   output logic receiveIdleFlag,
   output logic wakeRequest,
   // to the normal receiver
   output logic receiverHold,             // receiver forced idle
   output logic [15:0] baudDivisor
);

   // ************************************************************
   // line edge detect
   // ************************************************************
   logic rxLast;       // previous line level
   logic rxRise;
   logic rxFall;

   // line sampled on every rising clock edge; inputs are already synchronous
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxLast <= 1'b1;
      end else begin
         rxLast <= serialReceiveLine;
      end
   end

   assign rxRise = serialReceiveLine & ~rxLast;
   assign rxFall = ~serialReceiveLine & rxLast;

   // ************************************************************
   // calibration clock prescaler
   // ************************************************************
   logic [uab_pkg::PrescaleWidth-1:0] prescale;
   logic [uab_pkg::PrescaleWidth-1:0] prescaleLast;
   logic calibTick;

   // osc/512, /128, /32 depending on the select pair
   function automatic logic [uab_pkg::PrescaleWidth-1:0] calib_period(
      input logic wide, input logic high);
      int unsigned base;
      if (wide & high) begin
         base = uab_pkg::BaseDivFast;
      end else if (wide | high) begin
         base = uab_pkg::BaseDivMid;
      end else begin
         base = uab_pkg::BaseDivSlow;
      end
      return uab_pkg::PrescaleWidth'(base * uab_pkg::CalibDivide - 1);
   endfunction : calib_period

   assign prescaleLast = calib_period(wideDivisorSelect, highSpeedSelect);
   assign calibTick = (prescale == prescaleLast);

   // ************************************************************
   // calibration sequencer
   // ************************************************************
   uab_pkg::uab_cal_e calState;
   uab_pkg::uab_cal_e next_calState;
   logic [2:0] riseCount;     // rises seen inside the count
   logic calibDone;           // fifth rising edge this cycle
   logic breakPending;        // wake armed together with autobaud

   // measurement delayed past a break while wake is armed
   assign breakPending = wakeOnBreakEnable;

   assign calibDone = (calState == uab_pkg::CAL_COUNT) && rxRise &&
                      (riseCount == uab_pkg::SyncRiseCount - 3'h1);

   // next state of the sequencer
   always_comb begin
      next_calState = calState;
      unique case (calState)
         uab_pkg::CAL_IDLE: begin
            if (autobaudEnableSet) begin
               next_calState = uab_pkg::CAL_START;
            end
         end
         uab_pkg::CAL_START: begin
            // start bit fall, not the break's own fall
            if (rxFall && !breakPending) begin
               next_calState = uab_pkg::CAL_FIRST;
            end
         end
         uab_pkg::CAL_FIRST: begin
            if (rxRise) begin
               next_calState = uab_pkg::CAL_COUNT;
            end
         end
         uab_pkg::CAL_COUNT: begin
            if (calibDone) begin
               next_calState = uab_pkg::CAL_IDLE;
            end
         end
      endcase
      // software abort: receiver then sees later falls
      // a set in the same cycle wins, as it does for the enable bit,
      // so the state never disagrees with autobaudEnable
      if (autobaudEnableClear && !autobaudEnableSet) begin
         next_calState = uab_pkg::CAL_IDLE;
      end else if (autobaudEnableSet && calibDone) begin
         next_calState = uab_pkg::CAL_START;
      end
   end

   // sequencer state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         calState <= uab_pkg::CAL_IDLE;
      end else begin
         calState <= next_calState;
      end
   end

   // rises counted during the timed span
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         riseCount <= 3'h0;
      end else if (calState == uab_pkg::CAL_FIRST && rxRise) begin
         riseCount <= 3'h1;
      end else if (calState == uab_pkg::CAL_COUNT && rxRise) begin
         riseCount <= riseCount + 3'h1;
      end
   end

   // prescaler only runs while counting, restarts at the first rise
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prescale <= '0;
      end else if (calState != uab_pkg::CAL_COUNT || calibTick) begin
         prescale <= '0;
      end else begin
         prescale <= prescale + 1'b1;
      end
   end

   // ************************************************************
   // divisor pair and overflow
   // ************************************************************
   logic counting;
   assign counting = (calState == uab_pkg::CAL_COUNT);

   // one 16-bit counter whatever the wide select
   // starts at one, wraps and keeps going past overflow
   // value left in place is used by the receiver afterwards
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         baudDivisor <= uab_pkg::DivisorReset;
      end else if (calState == uab_pkg::CAL_FIRST && rxRise) begin
         baudDivisor <= uab_pkg::CalibStart;
      end else if (counting && calibTick) begin
         baudDivisor <= baudDivisor + 16'h0001;
      end else if (divisorWrite && !counting) begin
         baudDivisor <= divisorWriteData;
      end
   end

   logic overflowEvent;
   assign overflowEvent = counting && calibTick && (&baudDivisor) &&
                          !calibDone;

   // sticky overflow; the set wins over a software clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         autobaudOverflowFlag <= 1'b0;
      end else if (overflowEvent) begin
         autobaudOverflowFlag <= 1'b1;
      end else if (overflowFlagClear) begin
         autobaudOverflowFlag <= 1'b0;
      end
   end

   // enable bit: set by software, cleared at completion
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         autobaudEnable <= 1'b0;
      end else if (autobaudEnableSet) begin
         autobaudEnable <= 1'b1;
      end else if (calibDone || autobaudEnableClear) begin
         autobaudEnable <= 1'b0;
      end
   end

   // ************************************************************
   // wake on break
   // ************************************************************
   logic wakeFall;   // wake event this cycle
   logic wakeEnd;    // break-ending rise this cycle
   logic wakeSeen;   // fall taken, waiting for the rise

   // asynchronous mode only
   assign wakeFall = wakeOnBreakEnable && !wakeSeen && rxFall &&
                     !synchronousMode;
   // any rise ends the low time, even inside a data char
   assign wakeEnd = wakeOnBreakEnable && wakeSeen && rxRise;

   // wake enable set by software, cleared by hardware
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wakeOnBreakEnable <= 1'b0;
      end else if (wakeOnBreakEnableSet && !synchronousMode) begin
         wakeOnBreakEnable <= 1'b1;
      end else if (wakeEnd) begin
         wakeOnBreakEnable <= 1'b0;
      end
   end

   // tracks the low phase of the break
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wakeSeen <= 1'b0;
      end else if (wakeFall) begin
         wakeSeen <= 1'b1;
      end else if (wakeEnd || !wakeOnBreakEnable) begin
         wakeSeen <= 1'b0;
      end
   end

   // wake request to the power controller, pulse while asleep
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wakeRequest <= 1'b0;
      end else begin
         wakeRequest <= wakeFall && sleepMode;
      end
   end

   // ************************************************************
   // receive interrupt flag and idle flag
   // ************************************************************
   // sleep here only differs in the wake request; the clock is kept
   // running in this model, so the flag is always set synchronously
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         receiveInterruptFlag <= 1'b0;
      end else if (calibDone || overflowEvent || wakeFall ||
                   receiverCharDone) begin
         receiveInterruptFlag <= 1'b1;
      end else if (receiveDataRead) begin
         receiveInterruptFlag <= 1'b0;
      end
   end

   // receiver held idle during calibration and wake
   assign receiverHold = (calState != uab_pkg::CAL_IDLE) ||
                         wakeOnBreakEnable;

   // idle flag low through calibration, high at the fifth rise
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         receiveIdleFlag <= 1'b1;
      end else begin
         receiveIdleFlag <= (next_calState == uab_pkg::CAL_IDLE) &&
                            !receiverBusy;
      end
   end

endmodule : uab_autobaud_wake

// >>> hdl/uab_pkg.sv
/*
 * uab_pkg: constants shared by the autobaud / wake-on-break block.
 * assumes: single 100 MHz clock domain, active-low asynchronous reset.
 */
package uab_pkg;

   // ************************************************************
   // base clock prescale figures
   // ************************************************************
   // oscillator divide of the baud base clock per select pair
   localparam int unsigned BaseDivSlow = 64;   // 00
   localparam int unsigned BaseDivMid = 16;    // 01 or 10
   localparam int unsigned BaseDivFast = 4;    // 11
   // calibration counter runs at base clock / 8
   localparam int unsigned CalibDivide = 8;
   // counter width of the divisor pair
   localparam int unsigned DivisorWidth = 16;
   // prescaler counter width (512 max)
   localparam int unsigned PrescaleWidth = 10;
   // rising edges in a sync character
   localparam logic [2:0] SyncRiseCount = 3'h5;
   // calibration counter start value
   localparam logic [15:0] CalibStart = 16'h0001;
   // reset values
   localparam logic [15:0] DivisorReset = 16'h0000;

   // calibration sequencer states
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,   // not calibrating
      CAL_START = 2'b01,  // waiting for start bit fall
      CAL_FIRST = 2'b10,  // waiting for first rise
      CAL_COUNT = 2'b11   // counting rises 2..5
   } uab_cal_e;

endpackage : uab_pkg

// >>> tb/uab_autobaud_wake_bench.sv
/* uab_autobaud_wake_bench: self-checking bench of the autobaud block.
   assumes: uab_sender drives the line; monitor is bound separately. */
module uab_autobaud_wake_bench;
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************************
   // stimulus, instances and helpers
   // ************************************************************
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [6:0] strobe = 7'h00; // set clr wake ovf read write done
   logic wide = 1'b0;
   logic high = 1'b0;
   logic syncMode = 1'b0;
   logic sleep = 1'b0;
   logic busy = 1'b0;
   logic [15:0] writeData = 16'h0000;
   int wakeCount = 0; // wake pulses seen so far
   wire rxLine;
   wire abEn, ovf, wkEn, rxFlag, idle, wakeReq, hold;
   wire [15:0] divisor;
   int failCount = 0;
   int checks = 0;
   always #5 clk = ~clk;
   uab_autobaud_wake i_uab_autobaud_wake (
      .clk(clk), .resetn(resetn), .serialReceiveLine(rxLine),
      .autobaudEnableSet(strobe[0]), .autobaudEnableClear(strobe[1]),
      .wakeOnBreakEnableSet(strobe[2]), .overflowFlagClear(strobe[3]),
      .wideDivisorSelect(wide), .highSpeedSelect(high),
      .synchronousMode(syncMode), .sleepMode(sleep),
      .divisorWrite(strobe[5]), .divisorWriteData(writeData),
      .receiveDataRead(strobe[4]), .receiverCharDone(strobe[6]),
      .receiverBusy(busy), .autobaudEnable(abEn),
      .autobaudOverflowFlag(ovf), .wakeOnBreakEnable(wkEn),
      .receiveInterruptFlag(rxFlag), .receiveIdleFlag(idle),
      .wakeRequest(wakeReq), .receiverHold(hold), .baudDivisor(divisor));
   uab_sender i_uab_sender (.line(rxLine));
   // wake request lasts one cycle, so count it
   always @(posedge clk) begin
      if (wakeReq === 1'b1) wakeCount <= wakeCount + 1;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failCount++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // strobe one cycle, then let the flags settle
   task automatic pulse(input logic [6:0] s, input int gap);
      @(negedge clk) strobe = s;
      @(negedge clk) strobe = 7'h00;
      repeat (gap) @(negedge clk);
   endtask : pulse
   function automatic logic inRange(input logic [15:0] v, input int lo);
      return (v >= lo) && (v <= lo + 2);
   endfunction : inRange
   task automatic testReset();
      check({abEn, ovf, wkEn, rxFlag, idle, hold}, 6'b000010);
      check(divisor, 16'h0000);
      pulse(7'h08, 2);
      check(ovf, 1'b0);
      // a software load outside calibration must land
      writeData = 16'h1234;
      pulse(7'h20, 0);
      check(divisor, 16'h1234);
      busy = 1'b1;
      repeat (3) @(negedge clk);
      check(idle, 1'b0);
      busy = 1'b0;
      pulse(7'h40, 2);
      check(rxFlag, 1'b1);
      pulse(7'h10, 2);
      check(rxFlag, 1'b0);
   endtask : testReset
   // bit time is mult counter ticks; a write mid-count must be ignored
   task automatic testCalib(input logic [1:0] sel, input int mult);
      int div;
      div = (sel == 2'b00) ? 512 : ((sel == 2'b11) ? 32 : 128);
      {wide, high} = sel;
      pulse(7'h01, 2);
      check({abEn, hold, idle}, 3'b110);
      fork
         i_uab_sender.sendChar(8'h55, div * 10 * mult);
         begin
            #(div * 40 * mult);
            writeData = 16'hA5A5;
            pulse(7'h20, 0);
         end
      join
      repeat (4) @(negedge clk);
      check({abEn, rxFlag, idle}, 3'b011);
      check(ovf, 1'b0);
      check(inRange(divisor, 8 * mult), 1'b1);
      pulse(7'h10, 2);
      check(rxFlag, 1'b0);
      check(inRange(divisor, 8 * mult), 1'b1);
   endtask : testCalib
   task automatic testAbort();
      pulse(7'h01, 0);
      fork
         i_uab_sender.sendChar(8'h55, 320);
         begin
            #960;
            pulse(7'h02, 2);
            check({abEn, hold}, 2'b00);
         end
      join
      check(rxFlag, 1'b0);
   endtask : testAbort
   task automatic testWake(input logic slp, input logic [7:0] ch);
      int wakeBase;
      wakeBase = wakeCount;
      sleep = slp;
      check(idle, 1'b1);
      pulse(7'h04, 2);
      check({wkEn, hold}, 2'b11);
      fork
         i_uab_sender.sendChar(ch, 320);
         begin
            #160;
            check({rxFlag, wkEn}, 2'b11);
            check(16'(wakeCount - wakeBase), {15'h0000, slp});
         end
      join
      check(wkEn, 1'b0);
      pulse(7'h10, 2);
      check(rxFlag, 1'b0);
      sleep = 1'b0;
   endtask : testWake
   // break first, then the sync character is the one measured
   task automatic testWakeBaud();
      {wide, high} = 2'b11;
      pulse(7'h05, 2);
      i_uab_sender.sendChar(8'h00, 320);
      check({wkEn, abEn, rxFlag}, 3'b011);
      pulse(7'h10, 2);
      i_uab_sender.sendChar(8'h55, 320);
      repeat (4) @(negedge clk);
      check({abEn, rxFlag}, 2'b01);
      check(inRange(divisor, 8), 1'b1);
      pulse(7'h10, 2);
   endtask : testWakeBaud
   task automatic conclude();
      if (failCount == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      testReset();
      for (int s = 0; s < 4; s++) testCalib(s[1:0], 1);
      testCalib(2'b01, 34);
      testAbort();
      testWake(1'b1, 8'h00);
      testWake(1'b0, 8'h0F);
      syncMode = 1'b1;
      pulse(7'h04, 2);
      check(wkEn, 1'b0);
      syncMode = 1'b0;
      testWakeBaud();
      conclude();
   end
   // the run needs about 530 us; allow some margin beyond that
   initial begin
      #800000;
      failCount++;
      conclude();
   end
endmodule : uab_autobaud_wake_bench

// >>> tb/uab_autobaud_wake_monitor.sv
/* uab_autobaud_wake_monitor: port-level checks of uab_autobaud_wake.
   assumes: one clock domain, bound to every instance of the block. */
module uab_autobaud_wake_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // watched inputs
   input wire logic serialReceiveLine,
   input wire logic autobaudEnableSet,
   input wire logic autobaudEnableClear,
   input wire logic sleepMode,
   input wire logic divisorWrite,
   input wire logic receiveDataRead,
   input wire logic receiverCharDone,
   // watched outputs
   input wire logic autobaudEnable,
   input wire logic autobaudOverflowFlag,
   input wire logic wakeOnBreakEnable,
   input wire logic receiveInterruptFlag,
   input wire logic receiveIdleFlag,
   input wire logic wakeRequest,
   input wire logic receiverHold,
   input wire logic [15:0] baudDivisor
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************************
   // sequences and assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // fifth rise ends calibration; past reset guards a mid-run reset
   sequence calEnd;
      $fell(autobaudEnable) && $past(resetn) && !$past(autobaudEnableClear);
   endsequence
   // edges of the line while wake is armed
   sequence wakeFall;
      wakeOnBreakEnable && $fell(serialReceiveLine);
   endsequence
   sequence wakeRise;
      wakeOnBreakEnable && $rose(serialReceiveLine);
   endsequence
   AST_SET_START:
   assert property (autobaudEnableSet |=> autobaudEnable)
      else $error("autobaud enable did not set");
   AST_HOLD:
   assert property ((autobaudEnable || wakeOnBreakEnable) |-> receiverHold)
      else $error("receiver not held");
   AST_CAL_IDLE:
   assert property (autobaudEnable |-> !receiveIdleFlag)
      else $error("idle flag high in calibration");
   AST_CAL_END:
   assert property (calEnd |-> receiveInterruptFlag && receiveIdleFlag)
      else $error("calibration end without flags");
   AST_COUNT_STEP:
   assert property ($past(autobaudEnable) && !$past(divisorWrite)
      && (baudDivisor != $past(baudDivisor)) |->
      (baudDivisor == $past(baudDivisor) + 16'h0001)
      || (baudDivisor == 16'h0001))
      else $error("divisor did not step by one");
   AST_OVF_FLAG:
   assert property ($rose(autobaudOverflowFlag) |-> receiveInterruptFlag)
      else $error("overflow without receive flag");
   AST_READ_CLEAR:
   assert property (receiveDataRead && !receiverCharDone && !autobaudEnable
      && !wakeOnBreakEnable |=> !receiveInterruptFlag)
      else $error("read did not clear flag");
   AST_WAKE_FALL:
   assert property (wakeFall |-> ##[1:2] receiveInterruptFlag
      && (wakeRequest || !sleepMode))
      else $error("wake fall not flagged");
   AST_WAKE_END:
   assert property (wakeRise |-> ##[1:2] !wakeOnBreakEnable)
      else $error("wake enable not cleared");
endmodule : uab_autobaud_wake_monitor

bind uab_autobaud_wake uab_autobaud_wake_monitor i_uab_autobaud_wake_monitor (
   .clk(clk), .resetn(resetn), .serialReceiveLine(serialReceiveLine),
   .autobaudEnableSet(autobaudEnableSet),
   .autobaudEnableClear(autobaudEnableClear), .sleepMode(sleepMode),
   .divisorWrite(divisorWrite), .receiveDataRead(receiveDataRead),
   .receiverCharDone(receiverCharDone), .autobaudEnable(autobaudEnable),
   .autobaudOverflowFlag(autobaudOverflowFlag),
   .wakeOnBreakEnable(wakeOnBreakEnable),
   .receiveInterruptFlag(receiveInterruptFlag),
   .receiveIdleFlag(receiveIdleFlag), .wakeRequest(wakeRequest),
   .receiverHold(receiverHold), .baudDivisor(baudDivisor));

// >>> tb/uab_sender.sv
/* uab_sender: remote asynchronous transmitter driving the receive line.
   assumes: caller starts frames off the clock edge; line idles high. */
module uab_sender (
   // line to the device
   output logic line
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************************
   // frame generation
   // ************************************************************
   initial line = 1'b1;
   // start, eight data bits lsb first, stop; bit time in ns
   task automatic sendChar(input logic [7:0] data, input int bitNs);
      line = 1'b0;
      #(bitNs);
      for (int i = 0; i < 8; i++) begin
         line = data[i];
         #(bitNs);
      end
      line = 1'b1; // stop bit, then idle high
      #(bitNs);
   endtask : sendChar
endmodule : uab_sender
